// [hw/pin_steer_pkg.sv]
package pin_steer_pkg;
    typedef enum logic [2:0] {
        MODE_MII_MAC,
        MODE_MII_PHY,
        MODE_RMII_MAC,
        MODE_RMII_PHY,
        MODE_INT_PHY
    } port_mode_t;
    localparam logic [2:0] STRAP_RESET = 3'h0;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam int MGMT_CLK_HALF = 4;
    localparam logic [2:0] MGMT_DIV_RESET = 3'h0;
endpackage

// [hw/port_pin_steer.sv]
// Overview of operation
// - MII MAC: collision pin is an input
// - MII PHY: collision pin driven to MAC
// - MII PHY isolate disables collision, carrier drivers
// - MII MAC: carrier sense pin is input
// - MII PHY: carrier sense driven to MAC
// - RMII modes: collision, carrier, data3/2 unused
// - Slave management: clock and data from master
// - Master management: drive clock, exchange data
// - Straps captured on the third clock after reset release, then held
// - Port 1 MII MAC: receive bits 3..1
// - RMII: only bit 1 carries data
// - Internal PHY: port 1 pins unused
// - PHY modes isolate disables port 1 inputs
// - Port 0 mode strap selects port 0 mode
// - MII MAC: valid qualifies error only, data bits pass ungated
`timescale 1ns/1ps
module port_pin_steer
    import pin_steer_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] port0_mode_strap0,
    input wire logic [2:0] port1_mode_strap,
    input wire logic mgmt_master_sel,
    input wire logic port0_isolate,
    input wire logic port1_isolate,
    input wire logic port0_collision_pin_in,
    output logic port0_collision_pin_out,
    output logic port0_collision_pin_oe,
    input wire logic port0_carrier_sense_pin_in,
    output logic port0_carrier_sense_pin_out,
    output logic port0_carrier_sense_pin_oe,
    input wire logic core_collision,
    input wire logic core_carrier,
    output logic ext_collision,
    output logic ext_carrier,
    input wire logic port0_mgmt_clock_pin_in,
    output logic port0_mgmt_clock_pin_out,
    output logic port0_mgmt_clock_pin_oe,
    input wire logic port0_mgmt_data_pin_in,
    output logic port0_mgmt_data_pin_out,
    output logic port0_mgmt_data_pin_oe,
    input wire logic mgmt_out_data,
    input wire logic mgmt_out_en,
    output logic mgmt_in_data,
    output logic mgmt_clock_rise,
    input wire logic port1_in_data_bit3,
    input wire logic port1_in_data_bit2,
    input wire logic port1_in_data_bit1,
    input wire logic port1_in_data_valid,
    input wire logic port1_in_error,
    output logic [2:0] port1_data_hi,
    output logic port1_valid,
    output logic port1_error,
    output logic port1_input_enable,
    output port_mode_t port0_mode,
    output port_mode_t port1_mode
);
    logic [2:0] strap0_s1, strap0_s2, strap1_s1, strap1_s2;
    logic master_s1, master_s2, mgmt_master;
    logic captured;
    logic [1:0] fill;
    logic col_s1, col_s2, crs_s1, crs_s2, mdc_s1, mdc_s2, mdc_q, mdi_s1, mdi_s2;
    logic [2:0] d_s1, d_s2;
    logic dv_s1, dv_s2, er_s1, er_s2;
    logic [2:0] div_cnt;
    logic mdc_gen;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {strap0_s1, strap0_s2, strap1_s1, strap1_s2} <= {4{STRAP_RESET}};
            {master_s1, master_s2} <= 2'h0;
            {col_s1, col_s2, crs_s1, crs_s2} <= 4'h0;
            // Management data sync flops idle high, all other sync flops reset low
            {mdc_s1, mdc_s2, mdc_q} <= 3'h0;
            {mdi_s1, mdi_s2} <= 2'h3;
            fill <= 2'h0;
            {d_s1, d_s2} <= 6'h00;
            {dv_s1, dv_s2, er_s1, er_s2} <= 4'h0;
        end else begin
            fill <= {fill[0], 1'b1};
            strap0_s1 <= port0_mode_strap0;
            strap0_s2 <= strap0_s1;
            strap1_s1 <= port1_mode_strap;
            strap1_s2 <= strap1_s1;
            master_s1 <= mgmt_master_sel;
            master_s2 <= master_s1;
            col_s1 <= port0_collision_pin_in;
            col_s2 <= col_s1;
            crs_s1 <= port0_carrier_sense_pin_in;
            crs_s2 <= crs_s1;
            mdc_s1 <= port0_mgmt_clock_pin_in;
            mdc_s2 <= mdc_s1;
            mdc_q <= mdc_s2;
            mdi_s1 <= port0_mgmt_data_pin_in;
            mdi_s2 <= mdi_s1;
            d_s1 <= {port1_in_data_bit3, port1_in_data_bit2, port1_in_data_bit1};
            d_s2 <= d_s1;
            dv_s1 <= port1_in_data_valid;
            dv_s2 <= dv_s1;
            er_s1 <= port1_in_error;
            er_s2 <= er_s1;
        end
    end

    // Straps taken once the synchroniser holds pin levels, then held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            captured <= 1'b0;
            port0_mode <= MODE_MII_MAC;
            port1_mode <= MODE_MII_MAC;
            mgmt_master <= 1'b0;
        end else if (!captured && fill[1]) begin
            captured <= 1'b1;
            port0_mode <= (strap0_s2 > 3'h3) ? MODE_MII_MAC : port_mode_t'(strap0_s2);
            port1_mode <= (strap1_s2 > 3'h4) ? MODE_INT_PHY : port_mode_t'(strap1_s2);
            mgmt_master <= master_s2;
        end
    end

    wire p0_mii_mac = captured && port0_mode == MODE_MII_MAC;
    wire p0_mii_phy = captured && port0_mode == MODE_MII_PHY;
    wire p0_drive = p0_mii_phy && !port0_isolate;
    wire p1_mii_mac = port1_mode == MODE_MII_MAC;
    wire p1_mii_phy = port1_mode == MODE_MII_PHY;
    wire p1_rmii = port1_mode == MODE_RMII_MAC || port1_mode == MODE_RMII_PHY;
    wire p1_phy = p1_mii_phy || port1_mode == MODE_RMII_PHY;
    wire p1_enable = captured && port1_mode != MODE_INT_PHY && !(p1_phy && port1_isolate);
    wire p1_full = p1_enable && (p1_mii_mac || p1_mii_phy);
    wire mgmt_master_on = captured && mgmt_master;
    wire div_end = div_cnt == 3'(MGMT_CLK_HALF - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt <= MGMT_DIV_RESET;
            mdc_gen <= 1'b0;
        end else if (!mgmt_master_on) begin
            div_cnt <= MGMT_DIV_RESET;
            mdc_gen <= 1'b0;
        end else begin
            div_cnt <= div_end ? MGMT_DIV_RESET : div_cnt + 3'h1;
            mdc_gen <= div_end ? !mdc_gen : mdc_gen;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port0_collision_pin_out <= 1'b0;
            port0_collision_pin_oe <= 1'b0;
            port0_carrier_sense_pin_out <= 1'b0;
            port0_carrier_sense_pin_oe <= 1'b0;
            ext_collision <= 1'b0;
            ext_carrier <= 1'b0;
            port0_mgmt_clock_pin_out <= 1'b0;
            port0_mgmt_clock_pin_oe <= 1'b0;
            port0_mgmt_data_pin_out <= 1'b0;
            port0_mgmt_data_pin_oe <= 1'b0;
            mgmt_in_data <= 1'b1;
            mgmt_clock_rise <= 1'b0;
            port1_data_hi <= 3'h0;
            port1_valid <= 1'b0;
            port1_error <= 1'b0;
            port1_input_enable <= 1'b0;
        end else begin
            port0_collision_pin_out <= p0_drive && core_collision;
            port0_collision_pin_oe <= p0_drive;
            port0_carrier_sense_pin_out <= p0_drive && core_carrier;
            port0_carrier_sense_pin_oe <= p0_drive;
            ext_collision <= p0_mii_mac && col_s2;
            ext_carrier <= p0_mii_mac && crs_s2;
            port0_mgmt_clock_pin_out <= mgmt_master_on && mdc_gen;
            port0_mgmt_clock_pin_oe <= mgmt_master_on;
            port0_mgmt_data_pin_out <= mgmt_out_data;
            port0_mgmt_data_pin_oe <= captured && mgmt_out_en;
            mgmt_in_data <= mdi_s2;
            // Slave samples on master clock rise, master on own rise
            mgmt_clock_rise <= mgmt_master_on ? (div_end && !mdc_gen)
                : (captured && mdc_s2 && !mdc_q);
            port1_data_hi[2:1] <= p1_full ? d_s2[2:1] : 2'h0;
            port1_data_hi[0] <= p1_enable ? d_s2[0] : 1'b0;
            port1_valid <= p1_enable && dv_s2;
            port1_error <= p1_enable && dv_s2 && er_s2
                && port1_mode != MODE_RMII_PHY;
            port1_input_enable <= p1_enable;
        end
    end

    collision_drive_a: assert property (@(posedge clk) disable iff (rst)
        port0_collision_pin_oe |-> $past(p0_mii_phy) && !$past(port0_isolate))
        else $error("collision pin driven outside MII PHY or while isolated");
    carrier_unused_a: assert property (@(posedge clk) disable iff (rst)
        !$past(p0_mii_phy) |-> !port0_carrier_sense_pin_oe)
        else $error("carrier pin driven outside MII PHY");
    collision_input_a: assert property (@(posedge clk) disable iff (rst)
        ext_collision |-> $past(p0_mii_mac))
        else $error("collision taken outside MII MAC");
    carrier_follow_a: assert property (@(posedge clk) disable iff (rst)
        $past(p0_mii_mac) && $past(crs_s2) |-> ext_carrier)
        else $error("carrier input lost in MII MAC");
    strap_hold_a: assert property (@(posedge clk) disable iff (rst)
        $past(captured) |-> $stable(port0_mode) && $stable(port1_mode))
        else $error("mode changed after strap capture");
    mgmt_clock_a: assert property (@(posedge clk) disable iff (rst)
        mgmt_master_on && $rose(mdc_gen) |-> mdc_gen [*4] ##1 !mdc_gen)
        else $error("management clock period wrong");
    data_unused_a: assert property (@(posedge clk) disable iff (rst)
        $past(captured && port1_mode == MODE_INT_PHY) |-> !port1_input_enable
            && port1_data_hi == 3'h0)
        else $error("port 1 data used in internal PHY mode");
    rmii_hi_a: assert property (@(posedge clk) disable iff (rst)
        $past(p1_rmii) |-> port1_data_hi[2:1] == 2'h0)
        else $error("RMII upper data bits used");
    isolate_in_a: assert property (@(posedge clk) disable iff (rst)
        $past(p1_phy && port1_isolate) |-> !port1_input_enable && !port1_valid)
        else $error("port 1 inputs live while isolated");
    port0_mode_a: assert property (@(posedge clk) disable iff (rst)
        port0_mode != MODE_INT_PHY)
        else $error("port 0 took a mode it does not have");
    slave_clock_a: assert property (@(posedge clk) disable iff (rst)
        !$past(mgmt_master_on) |-> !port0_mgmt_clock_pin_oe)
        else $error("management clock driven in slave mode");
endmodule

// [test/far_side.sv]
`timescale 1ns/1ps
module far_side (
    input wire logic frame,
    input wire logic drive,
    input wire logic col_oe,
    input wire logic col_out,
    input wire logic crs_oe,
    input wire logic crs_out,
    input wire logic mdio_oe,
    input wire logic mdio_out,
    input wire logic mdc_oe,
    input wire logic mdc_out,
    output logic col,
    output logic crs,
    output logic mdio,
    output logic mdc
);
    logic link = 1'b0;
    // Pulled-up lines float high when nobody drives
    assign col = col_oe ? col_out : 1'b1;
    assign crs = crs_oe ? crs_out : (drive ? 1'b0 : 1'b1);
    assign mdio = mdio_oe ? mdio_out : 1'b1;
    assign mdc = mdc_oe ? mdc_out : link;
    // Master clock runs only inside a frame
    always #62.5 link = frame ? ~link : 1'b0;
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import pin_steer_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic m_sel = 1'b0;
    logic iso = 1'b0;
    logic frame = 1'b0;
    logic drive = 1'b1;
    logic valid = 1'b1;
    logic o_en = 1'b0;
    logic [2:0] p0s = 3'h0;
    logic [2:0] p1s = 3'h0;
    logic col, crs, mdio, mdc, col_out, col_oe, crs_out, crs_oe, ext_col, ext_crs, m_in;
    logic mdc_out, mdc_oe, mdio_out, mdio_oe, rise, p1v, p1e;
    logic [2:0] hi;
    logic [2:0] dat = 3'h7;
    logic p1ie;
    port_mode_t m1;
    int hcnt;
    logic [2:0] em;
    logic [11:0] r;
    port_mode_t m0;
    int n_errors = 0;
    int n_checks = 0;
    int cnt;
    logic [11:0] rows [7] = '{{3'h0, 3'h0, 1'h0, 3'h7, 1'h0, 1'h1},
        {3'h1, 3'h1, 1'h0, 3'h7, 1'h1, 1'h0}, {3'h1, 3'h1, 1'h1, 3'h0, 1'h0, 1'h0},
        {3'h2, 3'h2, 1'h0, 3'h1, 1'h0, 1'h0}, {3'h3, 3'h3, 1'h0, 3'h1, 1'h0, 1'h0},
        {3'h3, 3'h3, 1'h1, 3'h0, 1'h0, 1'h0}, {3'h5, 3'h4, 1'h0, 3'h0, 1'h0, 1'h1}};
    always #5 clk = ~clk;
    far_side i_far (.frame(frame), .drive(drive), .col_oe(col_oe), .col_out(col_out),
        .crs_oe(crs_oe), .crs_out(crs_out), .mdio_oe(mdio_oe), .mdio_out(mdio_out),
        .mdc_oe(mdc_oe), .mdc_out(mdc_out), .col(col), .crs(crs), .mdio(mdio), .mdc(mdc));
    port_pin_steer i_dut (.clk(clk), .rst(rst), .port0_mode_strap0(p0s),
        .port1_mode_strap(p1s), .mgmt_master_sel(m_sel), .port0_isolate(iso),
        .port1_isolate(iso), .port0_collision_pin_in(col), .port0_collision_pin_out(col_out),
        .port0_collision_pin_oe(col_oe), .port0_carrier_sense_pin_in(crs),
        .port0_carrier_sense_pin_out(crs_out), .port0_carrier_sense_pin_oe(crs_oe),
        .core_collision(1'b1), .core_carrier(1'b1), .ext_collision(ext_col),
        .ext_carrier(ext_crs), .port0_mgmt_clock_pin_in(mdc), .port0_mgmt_clock_pin_out(mdc_out),
        .port0_mgmt_clock_pin_oe(mdc_oe), .port0_mgmt_data_pin_in(mdio),
        .port0_mgmt_data_pin_out(mdio_out), .port0_mgmt_data_pin_oe(mdio_oe),
        .mgmt_out_data(1'b0), .mgmt_out_en(o_en), .mgmt_in_data(m_in), .mgmt_clock_rise(rise),
        .port1_in_data_bit3(dat[2]), .port1_in_data_bit2(dat[1]), .port1_in_data_bit1(dat[0]),
        .port1_in_data_valid(valid), .port1_in_error(1'b1), .port1_data_hi(hi),
        .port1_valid(p1v), .port1_error(p1e), .port1_input_enable(p1ie), .port0_mode(m0),
        .port1_mode(m1));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic boot(input logic [2:0] a, input logic [2:0] b, input logic ms);
        @(negedge clk);
        rst = 1'b1;
        p0s = a;
        p1s = b;
        m_sel = ms;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        results();
    end
    initial begin
        foreach (rows[i]) begin
            r = rows[i];
            iso = r[5];
            drive = !r[1];
            boot(r[11:9], r[8:6], 1'b0);
            em = (r[11:9] > 3'h3) ? 3'h0 : r[11:9];
            chk(hi, r[4:2]);
            chk(col_oe, r[1]);
            chk(crs_oe, r[1]);
            chk(crs_oe ? crs_out : 1'b1, 1'b1);
            chk(ext_col, r[0]);
            chk(ext_crs, 1'b0);
            chk(m0, em);
            chk(m1, r[8:6]);
            chk(p1ie, r[2]);
            chk(col_oe ? col_out : 1'b0, r[1]);
        end
        // Strap moves after capture, valid low
        boot(3'h0, 3'h0, 1'b0);
        p0s = 3'h1;
        valid = 1'b0;
        repeat (8) @(negedge clk);
        chk(m0, 3'h0);
        chk(col_oe, 1'b0);
        chk(p1e, 1'b0);
        valid = 1'b1;
        repeat (6) @(negedge clk);
        chk({p1v, p1e}, 2'h3);
        chk({mdc_oe, m_in}, 2'h1);
        cnt = 0;
        #1 frame = 1'b1;
        fork
            #1000 frame = 1'b0;
            repeat (115) begin
                @(negedge clk);
                cnt += rise;
            end
        join
        chk(cnt[7:0], 8'h08);
        boot(3'h0, 3'h0, 1'b1);
        o_en = 1'b1;
        cnt = 0;
        hcnt = 0;
        repeat (80) begin
            @(negedge clk);
            cnt += rise;
            hcnt += mdc_out;
        end
        chk(cnt[7:0], 8'h0A);
        chk(hcnt[7:0], 8'h28);
        chk({mdc_oe, mdio_oe, mdio_out, m_in}, 4'hC);
        // Carrier raised by the far side, data bits in their own places
        drive = 1'b0;
        dat = 3'h6;
        repeat (5) @(negedge clk);
        chk(ext_crs, 1'b1);
        chk(hi, 3'h6);
        results();
    end
endmodule
